//--- stc_params.svh
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// ************************************************************
// Register word indexes; byte address is four times the index.
// ************************************************************
`define STC_IDX_CTRL 8'h3A
`define STC_IDX_TRIG_BC 8'h3B
`define STC_IDX_N_LOW 8'h3C
`define STC_IDX_STATUS 8'h3D

// ************************************************************
// Field positions and reset values.
// ************************************************************
`define STC_BIT_RUN 0
`define STC_BIT_CLK_SEL 1
`define STC_BIT_PHASE_MOD 2
`define STC_CTRL_RESET 8'h00
`define STC_TRIG_BC_RESET 8'h00
`define STC_N_LOW_RESET 8'h00

// ************************************************************
// Fixed denominator exponent while sweeping.
// ************************************************************
`define STC_DEN_EXP 24

// ************************************************************
// Trigger source selector codes.
// ************************************************************
`define STC_SRC_NEVER 4'h0
`define STC_SRC_T1_RISE 4'h1
`define STC_SRC_T2_RISE 4'h2
`define STC_SRC_MOD_RISE 4'h3
`define STC_SRC_LOCK_RISE 4'h4
`define STC_SRC_COMPARATOR_ZERO_HIT 4'h5
`define STC_SRC_CPG_RISE 4'h6
`define STC_SRC_FLAG0_RISE 4'h7
`define STC_SRC_ALWAYS 4'h8
`define STC_SRC_T1_FALL 4'h9
`define STC_SRC_T2_FALL 4'hA
`define STC_SRC_MOD_FALL 4'hB
`define STC_SRC_UNUSED 4'hC
`define STC_SRC_COMPARATOR_ONE_HIT 4'hD
`define STC_SRC_CPG_FALL 4'hE
`define STC_SRC_FLAG0_FALL 4'hF

`endif

//--- stc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Pin model.
// ********
module stc_pin_model
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] level,
  output stc_pkg::stc_pins_t pins
);
  import stc_pkg::*;
  logic [1:0] div_q;
  // The phase detector clock runs free, four system cycles a period.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  // Trigger and modulation levels come from the bench, held for many cycles.
  assign pins = {div_q[1], level};
endmodule : stc_pin_model
`default_nettype wire

//--- stc_pkg.sv
package stc_pkg;

  // Pins arriving from outside the clock domain.
  typedef struct packed {
    logic pd_clock_pin;
    logic modulation_pin;
    logic trigger_pin_two;
    logic trigger_pin_one;
  } stc_pins_t;

  // Flags from on-chip logic on the same clock.
  typedef struct packed {
    logic segment_flag_zero;
    logic segment_pump_gain_flag;
    logic comparator_one_hit;
    logic comparator_zero_hit;
    logic digital_lock_flag;
  } stc_flags_t;

  // Trigger events handed to the ramp engine.
  typedef struct packed {
    logic event_c;
    logic event_b;
    logic event_a;
  } stc_events_t;

  typedef enum logic [0:0] {
    STC_IDLE,
    STC_RUN
  } stc_state_t;

endpackage : stc_pkg

//--- stc_sweep_trigger_control.sv
// Notes on behaviour
// RULE1 - Sweep functions work only while run bit set.
// RULE2 - Running forces fractional denominator to two^24.
// RULE3 - Integer low byte write starts first segment.
// RULE4 - Host configures sweep before setting run bit.
// RULE5 - Clock select: phase detector or modulation pin.
// RULE6 - Modulation type bit: frequency or phase.
// RULE7 - Three independent four-bit trigger source selectors.
// RULE8 - Codes 0 never; 1-4 pin/lock rising edges.
// RULE9 - Codes 6,7 rising edges of segment flags.
// RULE10 - Codes 9,10,11 falling pin edges.
// RULE11 - Codes 5,13 comparator levels; 8 always.
// RULE12 - Codes 14,15 falling edges of segment flags.
// RULE13 - Code 12 never; edges sampled on sweep clock.
`timescale 1ns/100ps
`default_nettype none
`include "stc_params.svh"

module stc_sweep_trigger_control
#(
  parameter int DEN_WIDTH = 24
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire stc_pkg::stc_pins_t pins,
  input wire stc_pkg::stc_flags_t flags,
  input wire logic [DEN_WIDTH-1:0] programmed_denominator,
  output logic [DEN_WIDTH:0] effective_denominator,
  output logic sweep_run,
  output logic sweep_tick,
  output logic phase_mod_select,
  output logic first_segment_start,
  output stc_pkg::stc_events_t events
);
  import stc_pkg::*;

  // ************************************************************
  // Register bus.
  // ************************************************************
  logic [7:0] ctrl_q;
  logic [7:0] trig_bc_q;
  logic [7:0] n_low_q;
  logic [31:0] readdata_q;
  logic rd_done_q;
  logic [7:0] index;
  logic wr_low;
  logic run_en;
  stc_state_t state_q;
  stc_events_t events_q;

  assign index = address[9:2];
  assign wr_low = write & byteenable[0];
  assign run_en = ctrl_q[`STC_BIT_RUN];

  // Reads take one wait cycle so read data always come from a flop.
  assign waitrequest = read & ~rd_done_q;

  // Writes land on the first cycle; byte lane 0 carries every field.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= `STC_CTRL_RESET;
      trig_bc_q <= `STC_TRIG_BC_RESET;
      n_low_q <= `STC_N_LOW_RESET;
    end
    else if (wr_low)
    begin
      if (index == `STC_IDX_CTRL)
        ctrl_q <= writedata[7:0]; // RULE7
      if (index == `STC_IDX_TRIG_BC)
        trig_bc_q <= writedata[7:0]; // RULE7
      if (index == `STC_IDX_N_LOW)
        n_low_q <= writedata[7:0];
    end
  end

  // Read data are captured in the wait cycle and held until taken.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      readdata_q <= 32'h0000_0000;
      rd_done_q <= 1'b0;
    end
    else
    begin
      rd_done_q <= read & ~rd_done_q;
      if (read & ~rd_done_q)
      begin
        case (index)
          `STC_IDX_CTRL: readdata_q <= {24'h00_0000, ctrl_q};
          `STC_IDX_TRIG_BC: readdata_q <= {24'h00_0000, trig_bc_q};
          `STC_IDX_N_LOW: readdata_q <= {24'h00_0000, n_low_q};
          `STC_IDX_STATUS: readdata_q <= {28'h000_0000,
            state_q == STC_RUN, events_q};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign readdata = readdata_q;

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  stc_pins_t pins_meta_q;
  stc_pins_t pins_sync_q;

  // Two stages; only the second stage feeds any logic.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pins_meta_q <= '0;
      pins_sync_q <= '0;
    end
    else
    begin
      pins_meta_q <= pins;
      pins_sync_q <= pins_meta_q;
    end
  end

  // ************************************************************
  // Sweep clock selection.
  // ************************************************************
  logic pd_prev_q;
  logic mod_prev_q;
  logic tick;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pd_prev_q <= 1'b0;
      mod_prev_q <= 1'b0;
    end
    else
    begin
      pd_prev_q <= pins_sync_q.pd_clock_pin;
      mod_prev_q <= pins_sync_q.modulation_pin;
    end
  end

  // A sweep clock tick is a rising edge of the chosen source; the
  // source must run well below half the system clock to be seen.
  assign tick = run_en & (ctrl_q[`STC_BIT_CLK_SEL] ? // RULE1
    (pins_sync_q.modulation_pin & ~mod_prev_q) : // RULE5
    (pins_sync_q.pd_clock_pin & ~pd_prev_q)); // RULE5

  // ************************************************************
  // Edge detection on sweep clock samples.
  // ************************************************************
  logic [5:0] src;
  logic [5:0] src_q;
  logic [5:0] prev_q;
  logic [5:0] rise;
  logic [5:0] fall;

  assign src = {flags.segment_flag_zero, flags.segment_pump_gain_flag,
    flags.digital_lock_flag, pins_sync_q.modulation_pin,
    pins_sync_q.trigger_pin_two, pins_sync_q.trigger_pin_one};

  // Sources are sampled only on ticks, so an edge that comes and goes
  // between two ticks is missed; that keeps all edge events on one cadence.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      src_q <= 6'h00;
      prev_q <= 6'h00;
    end
    else if (tick)
    begin
      src_q <= src; // RULE13
      prev_q <= src_q;
    end
  end

  assign rise = src_q & ~prev_q;
  assign fall = ~src_q & prev_q;

  // ************************************************************
  // Trigger selectors.
  // ************************************************************
  function automatic logic stc_hit(
    input logic [3:0] code,
    input logic [5:0] r,
    input logic [5:0] f,
    input logic c0,
    input logic c1
  );
    logic hit;
    begin
      hit = 1'b0;
      case (code)
        `STC_SRC_NEVER: hit = 1'b0; // RULE8
        `STC_SRC_T1_RISE: hit = r[0]; // RULE8
        `STC_SRC_T2_RISE: hit = r[1]; // RULE8
        `STC_SRC_MOD_RISE: hit = r[2]; // RULE8
        `STC_SRC_LOCK_RISE: hit = r[3]; // RULE8
        `STC_SRC_COMPARATOR_ZERO_HIT: hit = c0; // RULE11
        `STC_SRC_CPG_RISE: hit = r[4]; // RULE9
        `STC_SRC_FLAG0_RISE: hit = r[5]; // RULE9
        `STC_SRC_ALWAYS: hit = 1'b1; // RULE11
        `STC_SRC_T1_FALL: hit = f[0]; // RULE10
        `STC_SRC_T2_FALL: hit = f[1]; // RULE10
        `STC_SRC_MOD_FALL: hit = f[2]; // RULE10
        `STC_SRC_UNUSED: hit = 1'b0; // RULE13
        `STC_SRC_COMPARATOR_ONE_HIT: hit = c1; // RULE11
        `STC_SRC_CPG_FALL: hit = f[4]; // RULE12
        `STC_SRC_FLAG0_FALL: hit = f[5]; // RULE12
        default: hit = 1'b0;
      endcase
      return hit;
    end
  endfunction : stc_hit

  logic [11:0] sel_all;
  logic [2:0] hit_vec;

  assign sel_all = {trig_bc_q, ctrl_q[7:4]};

  // Edge codes only fire in the cycle after a tick updates samples;
  // level codes follow their source each cycle.
  logic edge_ok_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      edge_ok_q <= 1'b0;
    else
      edge_ok_q <= tick;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_trig
      assign hit_vec[gi] = stc_hit(sel_all[gi*4 +: 4], // RULE7
        rise & {6{edge_ok_q}}, fall & {6{edge_ok_q}},
        flags.comparator_zero_hit, flags.comparator_one_hit);
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      events_q <= '0;
    else
      events_q <= run_en ? stc_events_t'(hit_vec) : '0; // RULE1
  end

  assign events = events_q;

  // ************************************************************
  // Sweep start and state.
  // ************************************************************
  logic start_q;

  // A new low-byte write restarts from the first segment even while
  // running; clearing the run bit returns to idle at once.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= STC_IDLE;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= run_en & wr_low & (index == `STC_IDX_N_LOW); // RULE3
      case (state_q)
        STC_IDLE:
          if (run_en & wr_low & (index == `STC_IDX_N_LOW))
            state_q <= STC_RUN; // RULE3
        STC_RUN:
          if (!run_en)
            state_q <= STC_IDLE; // RULE1
        default: state_q <= STC_IDLE;
      endcase
    end
  end

  assign first_segment_start = start_q;

  // ************************************************************
  // Outputs steered by the control register.
  // ************************************************************
  logic [DEN_WIDTH:0] den_q;
  logic tick_q;
  logic pm_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      den_q <= '0;
      tick_q <= 1'b0;
      pm_q <= 1'b0;
    end
    else
    begin
      den_q <= run_en ? ((DEN_WIDTH+1)'(1) << `STC_DEN_EXP) : // RULE2
        {1'b0, programmed_denominator};
      tick_q <= tick & (state_q == STC_RUN); // RULE1
      pm_q <= ctrl_q[`STC_BIT_PHASE_MOD]; // RULE6
    end
  end

  assign effective_denominator = den_q;
  assign sweep_tick = tick_q;
  assign phase_mod_select = pm_q;
  assign sweep_run = state_q == STC_RUN;

endmodule : stc_sweep_trigger_control
`default_nettype wire

//--- stc_sweep_trigger_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Checker.
// ********
module stc_checker
#(
  parameter int DEN_WIDTH = 24
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [9:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [DEN_WIDTH-1:0] programmed_denominator,
  input wire logic [DEN_WIDTH:0] effective_denominator,
  input wire logic sweep_tick,
  input wire logic phase_mod_select,
  input wire logic first_segment_start,
  input wire stc_pkg::stc_events_t events
);
  import stc_pkg::*;
  logic run_q;
  logic pm_q;
  logic [3:0] a_q;
  wire logic hit = write && byteenable[0] && address[9:2] == 8'h3A;
  // Shadow of the control byte, so no probe into the design is needed.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      run_q <= 1'b0;
      pm_q <= 1'b0;
      a_q <= 4'h0;
    end
    else if (hit)
    begin
      run_q <= writedata[0];
      pm_q <= writedata[2];
      a_q <= writedata[7:4];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // A write of the integer low byte while the run bit is set.
  sequence s_start_wr;
    write && byteenable[0] && address[9:2] == 8'h3C && run_q;
  endsequence
  chk_idle_quiet: assert property (!run_q [*2] |->
    events == 3'h0 && !sweep_tick) else $error("activity while off");
  chk_den_fixed: assert property (run_q [*2] |->
    effective_denominator == 1 << 24) else $error("denominator not fixed");
  chk_den_prog: assert property (!run_q ##1 !run_q |->
    effective_denominator == {1'b0, $past(programmed_denominator)})
    else $error("programmed denominator lost");
  chk_start_pulse: assert property (s_start_wr |=>
    first_segment_start) else $error("no start pulse");
  chk_pm_follow: assert property ($changed(pm_q) |->
    ##[0:1] phase_mod_select == pm_q) else $error("modulation type wrong");
  chk_never_fire: assert property (
    (a_q == 4'h0 || a_q == 4'hC) [*2] |-> !events.event_a)
    else $error("idle source fired");
  chk_always_on: assert property ((run_q && a_q == 4'h8) [*2] |->
    events.event_a) else $error("constant source low");
  chk_edge_single: assert property (events.event_a &&
    !(a_q inside {4'h5, 4'h8, 4'hD}) |=> !events.event_a)
    else $error("edge event too long");
endmodule : stc_checker
bind stc_sweep_trigger_control stc_checker #(.DEN_WIDTH(DEN_WIDTH)) i_chk (
  .clock(clock), .resetn(resetn), .address(address), .write(write),
  .writedata(writedata), .byteenable(byteenable),
  .programmed_denominator(programmed_denominator),
  .effective_denominator(effective_denominator), .sweep_tick(sweep_tick),
  .phase_mod_select(phase_mod_select),
  .first_segment_start(first_segment_start), .events(events));
`default_nettype wire

//--- test_sweep_trigger_control.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Testbench.
// ********
module test_sweep_trigger_control;
  import stc_pkg::*;
  localparam int SRC [16] = '{0, 0, 1, 2, 3, 4, 5, 6, 0, 0, 1, 2, 0, 7, 5, 6};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  stc_pins_t pins;
  stc_flags_t flags;
  logic [7:0] s = 8'h00;
  logic [23:0] prog = 24'h0;
  logic [24:0] eff;
  logic run;
  logic tick;
  logic pm;
  logic start;
  stc_events_t ev;
  logic [31:0] q;
  logic [7:0] d;
  int miscompares = 0;
  int checks_done = 0;
  int tk;
  int c [3];
  // Flags ride the same stimulus vector as the pins, one bit per source.
  assign flags = {s[6], s[5], s[7], s[4], s[3]};
  initial forever #25 clock = ~clock;
  stc_pin_model i_pins (.clock(clock), .resetn(resetn), .level(s[2:0]),
    .pins(pins));
  stc_sweep_trigger_control i_dut (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pins(pins), .flags(flags), .programmed_denominator(prog),
    .effective_denominator(eff), .sweep_run(run), .sweep_tick(tick),
    .phase_mod_select(pm), .first_segment_start(start), .events(ev));
  task automatic results;
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input logic rd, input logic [7:0] idx,
    input logic [7:0] v);
    int n;
    @(posedge clock);
    address <= {idx, 2'b00};
    writedata <= {24'h0, v};
    read <= rd;
    write <= !rd;
    @(posedge clock);
    for (n = 1; waitrequest !== 1'b0 && n < 16; n++)
      @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // A slave that never answers ends the run here as a failure.
    if (waitrequest !== 1'b0)
    begin
      miscompares++;
      results();
    end
  endtask : bus
  // Counts ticks and event cycles; registered outputs are read at the edge.
  task automatic watch(input int n);
    repeat (n)
    begin
      @(posedge clock);
      chk(32'($isunknown({tick, ev})), 32'h0);
      tk += tick;
      for (int i = 0; i < 3; i++)
        c[i] += ev[i];
    end
  endtask : watch
  // Zero: never; one: a single pulse; two: a level of many cycles.
  function automatic int kind(input int k);
    return (k == 0 || k == 12) ? 0 : (k == 5 || k == 8 || k == 13) ? 2 : 1;
  endfunction : kind
  initial
  begin
    void'($urandom(32'hf1a6d62a));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b1, 8'h3A, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, 8'h3B, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, 8'h10, 8'h00);
    chk(q, 32'h0);
    repeat (3)
    begin
      d = 8'($urandom);
      bus(1'b0, 8'h3B, d);
      bus(1'b1, 8'h3B, 8'h00);
      chk(q, {24'h0, d});
    end
    byteenable <= 4'h0;
    bus(1'b0, 8'h3B, ~d);
    byteenable <= 4'hF;
    bus(1'b1, 8'h3B, 8'h00);
    chk(q, {24'h0, d});
    prog <= 24'($urandom);
    bus(1'b0, 8'h3A, 8'h04);
    bus(1'b0, 8'h3C, 8'h5A);
    repeat (3) @(posedge clock);
    chk(32'(eff), {8'h0, prog});
    chk(32'(pm), 32'h1);
    chk(32'(run), 32'h0);
    bus(1'b0, 8'h3A, 8'h01);
    bus(1'b0, 8'h3C, 8'($urandom));
    @(posedge clock);
    chk({30'h0, run, start}, 32'h3);
    chk(32'(eff), 32'h1000000);
    chk(32'(pm), 32'h0);
    bus(1'b0, 8'h3A, 8'h03);
    repeat (4) @(posedge clock);
    tk = 0;
    repeat (3)
    begin
      s[2] <= 1'b1;
      watch(5);
      s[2] <= 1'b0;
      watch(5);
    end
    chk(tk, 32'h3);
    for (int k = 0; k < 16; k++)
    begin
      bus(1'b0, 8'h3B, {k[3:0], k[3:0]});
      bus(1'b0, 8'h3A, {k[3:0], 4'h1});
      repeat (3) @(posedge clock);
      c = '{0, 0, 0};
      tk = 0;
      s[SRC[k]] <= 1'b1;
      watch(12);
      s[SRC[k]] <= 1'b0;
      watch(16);
      // The phase detector clock has a four-cycle period.
      chk(tk, 32'h7);
      if (k == 8)
      begin
        bus(1'b1, 8'h3D, 8'h00);
        chk(q, 32'hF);
      end
      for (int i = 0; i < 3; i++)
        chk(c[i] > 1 ? 2 : c[i], kind(k));
    end
    bus(1'b0, 8'h3A, 8'h80);
    repeat (3) @(posedge clock);
    chk({28'h0, run, ev}, 32'h0);
    bus(1'b1, 8'h3D, 8'h00);
    chk(q, 32'h0);
    results();
  end
endmodule : test_sweep_trigger_control
`default_nettype wire
